// [rtl/rdds_regs.vh]
// Purpose: Constants for the run-enable and dwell sequencer.
// Assumes: 100 MHz clk, frequencies in 0.01 Hz, times in 0.1 s.
// Notes:   Offsets are word indices on the plain register port.
// Operation
// - Run-enable mode 0 keeps operation permitted regardless of terminals.
// - Run-enable mode 1 takes permission from the assigned terminal.
// - Stop option 0 coasts: output block at once when permission drops.
// - Option 1 quick-stops; restart needs a fresh run command from outside.
// - Option 2 quick-stops, then resumes if permission returns with run on.
// - Quick-stop time 0.0 to 600.0 s, default 5.0 s, quick-stop only.
// - Start ramps to acc dwell frequency, holds, then accelerates to target.
// - Stop ramps to dec dwell frequency, holds, then decelerates to zero.
// - Dwell frequencies default 5.00 Hz, limited to start..maximum frequency.
// - A dwell with zero time or zero frequency is skipped.
// - Acc dwell only on first acceleration, not on resume or re-acceleration.
// - Dec dwell on stop ramps only, not on reference drops or brake control.
// - Dwell is available only when control mode is V/F, code 0.
`ifndef RDDS_REGS_VH
`define RDDS_REGS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define RDDS_OFF_RUN_EN_MODE  8'h00
`define RDDS_OFF_STOP_OPT     8'h01
`define RDDS_OFF_QSTOP_TIME   8'h02
`define RDDS_OFF_ACC_DW_FREQ  8'h03
`define RDDS_OFF_ACC_DW_TIME  8'h04
`define RDDS_OFF_DEC_DW_FREQ  8'h05
`define RDDS_OFF_DEC_DW_TIME  8'h06
`define RDDS_OFF_TARGET       8'h07
`define RDDS_OFF_ACC_TIME     8'h08
`define RDDS_OFF_DEC_TIME     8'h09
`define RDDS_OFF_START_FREQ   8'h0a
`define RDDS_OFF_MAX_FREQ     8'h0b
`define RDDS_OFF_CTRL_MODE    8'h0c
`define RDDS_OFF_TERM_FN0     8'h0d
`define RDDS_OFF_TERM_FN4     8'h11
`define RDDS_OFF_STATUS       8'h12
`define RDDS_OFF_FREQ         8'h13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RDDS_RST_RUN_EN_MODE  1'h1
`define RDDS_RST_STOP_OPT     2'h0
`define RDDS_RST_QSTOP_TIME   16'h0032
`define RDDS_RST_DW_FREQ      16'h01f4
`define RDDS_RST_DW_TIME      16'h0000
`define RDDS_RST_TARGET       16'h0000
`define RDDS_RST_RAMP_TIME    16'h0032
`define RDDS_RST_START_FREQ   16'h0032
`define RDDS_RST_MAX_FREQ     16'h1770
`define RDDS_RST_CTRL_MODE    2'h0
`define RDDS_RST_TERM_FN      6'h00

// ----------------------------------------
// Codes and limits
// ----------------------------------------
`define RDDS_FN_RUN_ENABLE    6'h0d
`define RDDS_RUNEN_ALWAYS     1'h0
`define RDDS_STOP_COAST       2'h0
`define RDDS_STOP_QSTOP       2'h1
`define RDDS_STOP_QRESUME     2'h2
`define RDDS_CTRL_VF          2'h0
`define RDDS_QSTOP_TIME_MAX   16'h1770
`define RDDS_ACC_DW_TIME_MAX  16'h0064
`define RDDS_DEC_DW_TIME_MAX  16'h0258

// ----------------------------------------
// Timing
// ----------------------------------------
`define RDDS_TICK_NS          100000000
`define RDDS_CLK_NS           10

`endif

// [rtl/rdds_sequencer.v]
// Purpose: Run-enable gate, stop options and dwell frequency sequencing.
// Assumes: Terminals and run command are asynchronous pins.
// Notes:   Ramp rate is full maximum frequency over the programmed time.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "rdds_regs.vh"

module rdds_sequencer #(
  parameter TICK_CYCLES = `RDDS_TICK_NS / `RDDS_CLK_NS
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [15:0] rdata_ff,
  input  wire [4:0]  multi_function_input,
  input  wire        run_cmd,
  input  wire        ext_brake,
  output reg  [15:0] freq_ff,
  output reg         out_block_ff
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] S_IDLE     = 4'h0;
  localparam [3:0] S_ACC_DW   = 4'h1;
  localparam [3:0] S_ACC_HOLD = 4'h2;
  localparam [3:0] S_RUN      = 4'h3;
  localparam [3:0] S_DEC_DW   = 4'h4;
  localparam [3:0] S_DEC_HOLD = 4'h5;
  localparam [3:0] S_DEC_STOP = 4'h6;
  localparam [3:0] S_QSTOP    = 4'h7;
  localparam [3:0] S_QS_WAIT  = 4'h8;

  localparam [39:0] TICK_C40  = TICK_CYCLES;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [39:0] ramp_cycles;
    input [15:0] t_ds;
    begin
      ramp_cycles = {24'h0, t_ds} * TICK_C40;
    end
  endfunction

  function [15:0] clamp_rng;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo)
        clamp_rng = lo;
      else if (v > hi)
        clamp_rng = hi;
      else
        clamp_rng = v;
    end
  endfunction

  // ----------------------------------------
  // Registers and synchronisers
  // ----------------------------------------
  reg         run_en_mode_ff;
  reg  [1:0]  stop_opt_ff;
  reg  [15:0] qstop_time_ff;
  reg  [15:0] acc_dw_freq_ff;
  reg  [15:0] acc_dw_time_ff;
  reg  [15:0] dec_dw_freq_ff;
  reg  [15:0] dec_dw_time_ff;
  reg  [15:0] target_ff;
  reg  [15:0] acc_time_ff;
  reg  [15:0] dec_time_ff;
  reg  [15:0] start_freq_ff;
  reg  [15:0] max_freq_ff;
  reg  [1:0]  ctrl_mode_ff;
  reg  [5:0]  term_fn_ff [0:4];
  reg  [4:0]  di_meta_ff;
  reg  [4:0]  di_sync_ff;
  reg         run_meta_ff;
  reg         run_sync_ff;
  reg         brk_meta_ff;
  reg         brk_sync_ff;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [15:0] timer_ff;
  reg  [15:0] nxt_timer;
  reg         dw_done_ff;
  reg         nxt_dw_done;
  reg  [39:0] acc_ff;
  reg  [39:0] nxt_acc;
  reg  [15:0] nxt_freq;
  reg  [15:0] setpoint;
  reg  [15:0] rate_time;
  reg  [39:0] acc_sum;
  reg  [39:0] rate_cyc;
  reg  [4:0]  fn_match;
  wire        tick;
  wire [15:0] status;
  wire        run_permit;
  wire        dwell_ok;
  wire        acc_dw_en;
  wire        dec_dw_en;
  wire [15:0] acc_dw_f;
  wire [15:0] dec_dw_f;
  wire [15:0] tgt;
  wire        at_sp;
  wire [2:0]  fn_idx;
  integer     i;
  integer     j;

  rdds_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick_ff (tick)
  );

  // Pins are asynchronous; only the second stage feeds logic
  always @(posedge clk) begin
    if (!rst_n) begin
      di_meta_ff  <= 5'h0;
      di_sync_ff  <= 5'h0;
      run_meta_ff <= 1'b0;
      run_sync_ff <= 1'b0;
      brk_meta_ff <= 1'b0;
      brk_sync_ff <= 1'b0;
    end else begin
      di_meta_ff  <= multi_function_input;
      di_sync_ff  <= di_meta_ff;
      run_meta_ff <= run_cmd;
      run_sync_ff <= run_meta_ff;
      brk_meta_ff <= ext_brake;
      brk_sync_ff <= brk_meta_ff;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  assign fn_idx = addr[2:0] - 3'h5;
  assign status = {9'h0, out_block_ff, dw_done_ff, run_permit, state_ff};

  always @(posedge clk) begin
    if (!rst_n) begin
      run_en_mode_ff <= `RDDS_RST_RUN_EN_MODE;
      stop_opt_ff    <= `RDDS_RST_STOP_OPT;
      qstop_time_ff  <= `RDDS_RST_QSTOP_TIME;
      acc_dw_freq_ff <= `RDDS_RST_DW_FREQ;
      acc_dw_time_ff <= `RDDS_RST_DW_TIME;
      dec_dw_freq_ff <= `RDDS_RST_DW_FREQ;
      dec_dw_time_ff <= `RDDS_RST_DW_TIME;
      target_ff      <= `RDDS_RST_TARGET;
      acc_time_ff    <= `RDDS_RST_RAMP_TIME;
      dec_time_ff    <= `RDDS_RST_RAMP_TIME;
      start_freq_ff  <= `RDDS_RST_START_FREQ;
      max_freq_ff    <= `RDDS_RST_MAX_FREQ;
      ctrl_mode_ff   <= `RDDS_RST_CTRL_MODE;
      for (i = 0; i < 5; i = i + 1) begin
        term_fn_ff[i] <= `RDDS_RST_TERM_FN;
      end
    end else if (wr_en) begin
      if (addr == `RDDS_OFF_RUN_EN_MODE) begin
        run_en_mode_ff <= wdata[0];
      end else if (addr == `RDDS_OFF_STOP_OPT) begin
        // Code 3 is not an option; fall back to coast
        stop_opt_ff <= (wdata[1:0] == 2'h3) ? `RDDS_STOP_COAST : wdata[1:0];
      end else if (addr == `RDDS_OFF_QSTOP_TIME) begin
        qstop_time_ff <= clamp_rng(wdata, 16'h0,
                                   `RDDS_QSTOP_TIME_MAX);
      end else if (addr == `RDDS_OFF_ACC_DW_FREQ) begin
        acc_dw_freq_ff <= wdata;
      end else if (addr == `RDDS_OFF_ACC_DW_TIME) begin
        acc_dw_time_ff <= clamp_rng(wdata, 16'h0,
                                    `RDDS_ACC_DW_TIME_MAX);
      end else if (addr == `RDDS_OFF_DEC_DW_FREQ) begin
        dec_dw_freq_ff <= wdata;
      end else if (addr == `RDDS_OFF_DEC_DW_TIME) begin
        dec_dw_time_ff <= clamp_rng(wdata, 16'h0,
                                    `RDDS_DEC_DW_TIME_MAX);
      end else if (addr == `RDDS_OFF_TARGET) begin
        target_ff <= wdata;
      end else if (addr == `RDDS_OFF_ACC_TIME) begin
        acc_time_ff <= wdata;
      end else if (addr == `RDDS_OFF_DEC_TIME) begin
        dec_time_ff <= wdata;
      end else if (addr == `RDDS_OFF_START_FREQ) begin
        start_freq_ff <= wdata;
      end else if (addr == `RDDS_OFF_MAX_FREQ) begin
        max_freq_ff <= wdata;
      end else if (addr == `RDDS_OFF_CTRL_MODE) begin
        ctrl_mode_ff <= wdata[1:0];
      end else if (addr >= `RDDS_OFF_TERM_FN0 &&
                   addr <= `RDDS_OFF_TERM_FN4) begin
        term_fn_ff[fn_idx] <= wdata[5:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n || !rd_en) begin
      rdata_ff <= 16'h0;
    end else if (addr == `RDDS_OFF_RUN_EN_MODE) begin
      rdata_ff <= {15'h0, run_en_mode_ff};
    end else if (addr == `RDDS_OFF_STOP_OPT) begin
      rdata_ff <= {14'h0, stop_opt_ff};
    end else if (addr == `RDDS_OFF_QSTOP_TIME) begin
      rdata_ff <= qstop_time_ff;
    end else if (addr == `RDDS_OFF_ACC_DW_FREQ) begin
      rdata_ff <= acc_dw_freq_ff;
    end else if (addr == `RDDS_OFF_ACC_DW_TIME) begin
      rdata_ff <= acc_dw_time_ff;
    end else if (addr == `RDDS_OFF_DEC_DW_FREQ) begin
      rdata_ff <= dec_dw_freq_ff;
    end else if (addr == `RDDS_OFF_DEC_DW_TIME) begin
      rdata_ff <= dec_dw_time_ff;
    end else if (addr == `RDDS_OFF_TARGET) begin
      rdata_ff <= target_ff;
    end else if (addr == `RDDS_OFF_ACC_TIME) begin
      rdata_ff <= acc_time_ff;
    end else if (addr == `RDDS_OFF_DEC_TIME) begin
      rdata_ff <= dec_time_ff;
    end else if (addr == `RDDS_OFF_START_FREQ) begin
      rdata_ff <= start_freq_ff;
    end else if (addr == `RDDS_OFF_MAX_FREQ) begin
      rdata_ff <= max_freq_ff;
    end else if (addr == `RDDS_OFF_CTRL_MODE) begin
      rdata_ff <= {14'h0, ctrl_mode_ff};
    end else if (addr >= `RDDS_OFF_TERM_FN0 &&
                 addr <= `RDDS_OFF_TERM_FN4) begin
      rdata_ff <= {10'h0, term_fn_ff[fn_idx]};
    end else if (addr == `RDDS_OFF_STATUS) begin
      rdata_ff <= status;
    end else if (addr == `RDDS_OFF_FREQ) begin
      rdata_ff <= freq_ff;
    end else begin
      rdata_ff <= 16'h0;
    end
  end

  // ----------------------------------------
  // Permission and dwell qualification
  // ----------------------------------------
  always @* begin
    for (j = 0; j < 5; j = j + 1) begin
      fn_match[j] = (term_fn_ff[j] == `RDDS_FN_RUN_ENABLE);
    end
  end

  // No terminal assigned means nothing can withhold permission
  assign run_permit = (run_en_mode_ff == `RDDS_RUNEN_ALWAYS) ||
                      (fn_match == 5'h0) ||
                      ((di_sync_ff & fn_match) != 5'h0);

  assign dwell_ok  = (ctrl_mode_ff == `RDDS_CTRL_VF);
  assign acc_dw_en = dwell_ok && (acc_dw_time_ff != 16'h0) &&
                     (acc_dw_freq_ff != 16'h0);
  assign dec_dw_en = dwell_ok && (dec_dw_time_ff != 16'h0) &&
                     (dec_dw_freq_ff != 16'h0);
  assign acc_dw_f  = clamp_rng(acc_dw_freq_ff, start_freq_ff,
                               max_freq_ff);
  assign dec_dw_f  = clamp_rng(dec_dw_freq_ff, start_freq_ff,
                               max_freq_ff);
  assign tgt       = (target_ff > max_freq_ff) ? max_freq_ff : target_ff;
  assign at_sp     = (freq_ff == setpoint);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    nxt_state   = state_ff;
    nxt_timer   = timer_ff;
    nxt_dw_done = dw_done_ff;
    case (state_ff)
      S_IDLE: begin
        if (!run_sync_ff) begin
          nxt_dw_done = 1'b0;
        end else if (run_permit) begin
          if (acc_dw_en && !dw_done_ff && tgt > acc_dw_f) begin
            nxt_state   = S_ACC_DW;
            nxt_dw_done = 1'b1;
          end else begin
            nxt_state = S_RUN;
          end
        end
      end
      S_ACC_DW: begin
        if (at_sp) begin
          nxt_state = S_ACC_HOLD;
          nxt_timer = 16'h0;
        end
      end
      S_ACC_HOLD: begin
        if (timer_ff >= acc_dw_time_ff) begin
          nxt_state = S_RUN;
        end else if (tick) begin
          nxt_timer = timer_ff + 16'h1;
        end
      end
      S_DEC_DW: begin
        if (brk_sync_ff) begin
          nxt_state = S_DEC_STOP;
        end else if (at_sp) begin
          nxt_state = S_DEC_HOLD;
          nxt_timer = 16'h0;
        end
      end
      S_DEC_HOLD: begin
        if (timer_ff >= dec_dw_time_ff) begin
          nxt_state = S_DEC_STOP;
        end else if (tick) begin
          nxt_timer = timer_ff + 16'h1;
        end
      end
      S_DEC_STOP: begin
        if (freq_ff == 16'h0) begin
          nxt_state = S_IDLE;
        end
      end
      S_QSTOP: begin
        if (freq_ff == 16'h0) begin
          nxt_state = S_QS_WAIT;
        end
      end
      S_QS_WAIT: begin
        if (!run_sync_ff) begin
          nxt_state = S_IDLE;
        end else if (stop_opt_ff == `RDDS_STOP_QRESUME && run_permit) begin
          nxt_state = S_RUN;
        end
      end
      default: begin
        nxt_state = state_ff;
      end
    endcase
    // Stop and re-run requests from the acc, run and dec states
    if (state_ff == S_ACC_DW || state_ff == S_ACC_HOLD ||
        state_ff == S_RUN) begin
      if (!run_sync_ff) begin
        if (dec_dw_en && !brk_sync_ff && freq_ff > dec_dw_f)
          nxt_state = S_DEC_DW;
        else
          nxt_state = S_DEC_STOP;
      end
    end else if (state_ff == S_DEC_DW || state_ff == S_DEC_HOLD ||
                 state_ff == S_DEC_STOP) begin
      if (run_sync_ff)
        nxt_state = S_RUN;
    end
    // Loss of permission overrides everything while active
    if (state_ff != S_IDLE && state_ff != S_QSTOP &&
        state_ff != S_QS_WAIT && !run_permit) begin
      if (stop_opt_ff == `RDDS_STOP_COAST)
        nxt_state = S_IDLE;
      else
        nxt_state = S_QSTOP;
    end
  end

  // ----------------------------------------
  // Ramp engine
  // ----------------------------------------
  // One 0.01 Hz step per overflow; full scale spans the ramp time
  always @* begin
    setpoint  = 16'h0;
    rate_time = 16'h0;
    case (state_ff)
      S_ACC_DW, S_ACC_HOLD: begin
        setpoint  = acc_dw_f;
        rate_time = acc_time_ff;
      end
      S_RUN: begin
        setpoint  = tgt;
        rate_time = (freq_ff < tgt) ? acc_time_ff : dec_time_ff;
      end
      S_DEC_DW, S_DEC_HOLD: begin
        setpoint  = dec_dw_f;
        rate_time = dec_time_ff;
      end
      S_DEC_STOP: begin
        rate_time = dec_time_ff;
      end
      S_QSTOP: begin
        rate_time = qstop_time_ff;
      end
      default: begin
        setpoint  = 16'h0;
      end
    endcase
    rate_cyc = ramp_cycles(rate_time);
    acc_sum  = acc_ff + {24'h0, max_freq_ff};
    nxt_freq = freq_ff;
    nxt_acc  = 40'h0;
    if (state_ff == S_IDLE || state_ff == S_QS_WAIT) begin
      nxt_freq = 16'h0;
    end else if (!at_sp) begin
      if (rate_cyc == 40'h0) begin
        nxt_freq = setpoint;
      end else if (acc_sum >= rate_cyc) begin
        nxt_acc  = acc_sum - rate_cyc;
        nxt_freq = (freq_ff < setpoint) ? freq_ff + 16'h1 :
                                          freq_ff - 16'h1;
      end else begin
        nxt_acc = acc_sum;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff     <= S_IDLE;
      timer_ff     <= 16'h0;
      dw_done_ff   <= 1'b0;
      acc_ff       <= 40'h0;
      freq_ff      <= 16'h0;
      out_block_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      timer_ff     <= nxt_timer;
      dw_done_ff   <= nxt_dw_done;
      acc_ff       <= nxt_acc;
      freq_ff      <= (nxt_state == S_IDLE) ? 16'h0 : nxt_freq;
      out_block_ff <= (nxt_state == S_IDLE) ||
                      (nxt_state == S_QS_WAIT);
    end
  end

endmodule // rdds_sequencer

// [rtl/rdds_tick.v]
// Purpose: 0.1 s time-base tick from the system clock.
// Assumes: Synchronous active-low reset.
// Notes:   One-cycle pulse every TICK_CYCLES clocks.
`timescale 1ns/1ps
`include "rdds_regs.vh"

module rdds_tick #(
  parameter TICK_CYCLES = `RDDS_TICK_NS / `RDDS_CLK_NS
) (
  input  wire        clk,
  input  wire        rst_n,
  output reg         tick_ff
);

  localparam [31:0] LAST = TICK_CYCLES - 1;

  reg  [31:0] cnt_ff;

  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= LAST) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

endmodule // rdds_tick

// [verification/rdds_field_model.sv]
// Purpose: Terminals, run command and brake seen by the sequencer
// Assumes: Levels set by the bench, launched after a clock edge
// Notes:   Spare terminals toggle so only coded ones may matter
`timescale 1ns/1ps
module rdds_field_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       permit_lvl,
  input  wire       run_lvl,
  input  wire       brake_lvl,
  input  wire       restart_req,
  output reg  [4:0] multi_function_input = 5'h0a,
  output reg        run_cmd = 1'b0,
  output reg        ext_brake = 1'b0
);
  reg [2:0] gap_ff;
  always @(posedge clk) begin
    if (!rst_n) begin
      gap_ff <= 3'h0;
    end else if (restart_req) begin
      gap_ff <= 3'h4;
    end else if (gap_ff != 3'h0) begin
      gap_ff <= gap_ff - 3'h1;
    end
    // Uncoded pins toggle to expose a wrong terminal pick
    multi_function_input <= {~multi_function_input[4:3], permit_lvl,
                             ~multi_function_input[1:0]};
    // Operator reissues run: low for a few cycles, then high
    run_cmd <= run_lvl && gap_ff == 3'h0 && !restart_req;
    ext_brake <= brake_lvl;
  end
endmodule // rdds_field_model

// [verification/rdds_sequencer_props.sv]
// Purpose: Port-level checks for the run-enable and dwell sequencer
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only top ports; bound after endmodule
`timescale 1ns/1ps
module rdds_sequencer_props #(
  parameter TICK_CYCLES = 100
) (
  input wire        clk,
  input wire        rst_n,
  input wire [7:0]  addr,
  input wire [15:0] wdata,
  input wire        wr_en,
  input wire        rd_en,
  input wire [15:0] rdata_ff,
  input wire [4:0]  multi_function_input,
  input wire        run_cmd,
  input wire        ext_brake,
  input wire [15:0] freq_ff,
  input wire        out_block_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_vals:
    assert property ($rose(rst_n) |-> out_block_ff && freq_ff == 16'h0000)
    else $error("outputs not at reset value after release");
  a_rdata_idle:
    assert property (!$past(rd_en) |-> rdata_ff == 16'h0000)
    else $error("read data not zero outside read answer");
  a_rd_freq:
    assert property (rd_en && addr == 8'h13 |=> rdata_ff == $past(freq_ff))
    else $error("frequency read back wrong");
  a_rd_status:
    assert property (rd_en && addr == 8'h12 |=>
      rdata_ff[6] == $past(out_block_ff) && rdata_ff[15:7] == 9'h000)
    else $error("status block bit wrong");
  a_unmapped_rd:
    assert property (rd_en && addr > 8'h13 |=> rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  a_block_zero:
    assert property (out_block_ff |-> freq_ff == 16'h0000)
    else $error("frequency driven while output blocked");
  a_start_gate:
    assert property ($past(freq_ff) == 16'h0000 && freq_ff != 16'h0000
      |-> $past(run_cmd, 2))
    else $error("output started without run command");
  a_idle_hold:
    assert property (freq_ff == 16'h0000 && !run_cmd && !$past(run_cmd)
      && !$past(run_cmd, 2) |=> freq_ff == 16'h0000)
    else $error("output left zero with run command off");
endmodule // rdds_sequencer_props

bind rdds_sequencer rdds_sequencer_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata_ff(rdata_ff), .multi_function_input(multi_function_input),
  .run_cmd(run_cmd), .ext_brake(ext_brake), .freq_ff(freq_ff),
  .out_block_ff(out_block_ff));

// [verification/rdds_sequencer_tb.sv]
// Purpose: Self-checking bench for the run-enable and dwell sequencer
// Assumes: Short tick (100 clocks) so 0.1 s is 100 cycles
// Notes:   Ramp times 0 make ramps jumps, except the quick-stop
`timescale 1ns/1ps
`include "rdds_regs.vh"
module rdds_sequencer_tb;
  localparam TK = 100;
  reg         clk;
  reg         rst_n;
  reg         wr_en;
  reg         rd_en;
  reg  [7:0]  addr;
  reg  [15:0] wdata;
  reg  [15:0] rv;
  reg         permit;
  reg         run;
  reg         brake;
  reg         rstrt;
  wire [15:0] rdata_ff;
  wire [15:0] freq_ff;
  wire        out_block_ff;
  wire [4:0]  mfi;
  wire        run_cmd;
  wire        ext_brake;
  integer     error_cnt;
  integer     samples_checked;
  integer     i;

  rdds_sequencer #(.TICK_CYCLES(TK)) u_rdds_sequencer (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_ff(rdata_ff), .multi_function_input(mfi),
    .run_cmd(run_cmd), .ext_brake(ext_brake), .freq_ff(freq_ff),
    .out_block_ff(out_block_ff));
  rdds_field_model u_rdds_field_model (
    .clk(clk), .rst_n(rst_n), .permit_lvl(permit), .run_lvl(run),
    .brake_lvl(brake), .restart_req(rstrt), .multi_function_input(mfi),
    .run_cmd(run_cmd), .ext_brake(ext_brake));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input [127:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 rv = rdata_ff;
    end
  endtask
  task wrchk(input [7:0] a, input [15:0] d, input [15:0] e);
    begin
      wr(a, d);
      rd(a);
      chk("reg write", rv, e);
    end
  endtask
  task pin(input p, input r, input b);
    begin
      @(posedge clk);
      permit <= p;
      run <= r;
      brake <= b;
    end
  endtask
  // Waits, then settles past the edge before outputs are looked at
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task cf(input [15:0] e);
    begin
      chk("freq", freq_ff, e);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    reg [15:0] e [0:17];
    begin
      e = '{16'h0001, 16'h0000, 16'h0032, 16'h01f4, 16'h0000, 16'h01f4,
            16'h0000, 16'h0000, 16'h0032, 16'h0032, 16'h0032, 16'h1770,
            16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      for (i = 0; i < 18; i = i + 1) begin
        rd(i[7:0]);
        chk("reset value", rv, e[i]);
      end
      wrchk(`RDDS_OFF_QSTOP_TIME, 16'h1b58, 16'h1770);
      wrchk(`RDDS_OFF_ACC_DW_TIME, 16'h00c8, 16'h0064);
      wrchk(`RDDS_OFF_DEC_DW_TIME, 16'h02bc, 16'h0258);
      wrchk(`RDDS_OFF_STOP_OPT, 16'h0003, 16'h0000);
      wrchk(8'h20, 16'h0005, 16'h0000);
      $display("t_regs done");
    end
  endtask
  task t_gate;
    begin
      wr(`RDDS_OFF_MAX_FREQ, 16'h03e8);
      wr(`RDDS_OFF_ACC_TIME, 16'h0000);
      wr(`RDDS_OFF_DEC_TIME, 16'h0000);
      wr(`RDDS_OFF_DEC_DW_TIME, 16'h0000);
      wr(`RDDS_OFF_ACC_DW_TIME, 16'h0000);
      wr(`RDDS_OFF_TARGET, 16'h0320);
      wr(8'h0f, 16'h000d);
      pin(1'b1, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0320);
      pin(1'b0, 1'b1, 1'b0);
      cyc(4);
      chk("block", {15'h0000, out_block_ff}, 16'h0001);
      pin(1'b0, 1'b0, 1'b0);
      pin(1'b0, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0000);
      pin(1'b1, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0320);
      wr(`RDDS_OFF_RUN_EN_MODE, 16'h0000);
      pin(1'b0, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0320);
      pin(1'b0, 1'b0, 1'b0);
      cyc(20);
      wr(`RDDS_OFF_RUN_EN_MODE, 16'h0001);
      $display("t_gate done");
    end
  endtask
  task t_qstop;
    begin
      wr(`RDDS_OFF_STOP_OPT, 16'h0001);
      wr(`RDDS_OFF_QSTOP_TIME, 16'h0001);
      pin(1'b1, 1'b1, 1'b0);
      cyc(20);
      pin(1'b0, 1'b1, 1'b0);
      cyc(50);
      // Plain decel time is 0, so a partial value proves the stop time
      chk("qs ramp", {15'h0000, freq_ff > 0 && freq_ff < 800}, 16'h0001);
      chk("qs block", {15'h0000, out_block_ff}, 16'h0000);
      cyc(1000);
      cf(16'h0000);
      pin(1'b1, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0000);
      @(posedge clk);
      rstrt <= 1'b1;
      @(posedge clk);
      rstrt <= 1'b0;
      cyc(30);
      cf(16'h0320);
      wr(`RDDS_OFF_STOP_OPT, 16'h0002);
      wr(`RDDS_OFF_QSTOP_TIME, 16'h0000);
      pin(1'b0, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0000);
      pin(1'b1, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0320);
      pin(1'b1, 1'b0, 1'b0);
      cyc(20);
      $display("t_qstop done");
    end
  endtask
  task t_dwell;
    begin
      wr(`RDDS_OFF_ACC_DW_FREQ, 16'h012c);
      wr(`RDDS_OFF_ACC_DW_TIME, 16'h0003);
      wr(`RDDS_OFF_DEC_DW_FREQ, 16'h0014);
      wr(`RDDS_OFF_DEC_DW_TIME, 16'h0003);
      pin(1'b1, 1'b1, 1'b0);
      cyc(100);
      cf(16'h012c);
      rd(`RDDS_OFF_FREQ);
      chk("freq read", rv, 16'h012c);
      rd(`RDDS_OFF_STATUS);
      chk("state", {12'h000, rv[3:0]}, 16'h0002);
      cyc(400);
      cf(16'h0320);
      wr(`RDDS_OFF_TARGET, 16'h0258);
      cyc(20);
      cf(16'h0258);
      pin(1'b1, 1'b0, 1'b0);
      cyc(100);
      cf(16'h0032);
      pin(1'b1, 1'b1, 1'b0);
      cyc(50);
      cf(16'h0258);
      pin(1'b1, 1'b0, 1'b1);
      cyc(20);
      cf(16'h0000);
      pin(1'b1, 1'b0, 1'b0);
      wr(`RDDS_OFF_CTRL_MODE, 16'h0001);
      pin(1'b1, 1'b1, 1'b0);
      cyc(50);
      cf(16'h0258);
      pin(1'b1, 1'b0, 1'b0);
      cyc(20);
      cf(16'h0000);
      wr(`RDDS_OFF_CTRL_MODE, 16'h0000);
      wr(`RDDS_OFF_ACC_DW_TIME, 16'h0000);
      pin(1'b1, 1'b1, 1'b0);
      cyc(20);
      cf(16'h0258);
      pin(1'b1, 1'b0, 1'b0);
      cyc(100);
      cf(16'h0032);
      cyc(400);
      cf(16'h0000);
      $display("t_dwell done");
    end
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tests need about 2700 cycles; allow about fifteen times that
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    permit = 1'b0;
    run = 1'b0;
    brake = 1'b0;
    rstrt = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_gate;
    t_qstop;
    t_dwell;
    end_sim;
  end
endmodule // rdds_sequencer_tb
